// [src/port_power_ctrl.sv]
// Pin and mode logic of a USB port power controller with a Wishbone register slave.
// Assumes pins are asynchronous; current and comparator inputs come from clk_i logic.
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps

//
// Contract
// - Each mode, emulation and enable control is pin level OR register bit.
// - Polarity select decides whether the port enable pin is active high or low.
// - Interface select picks register control or pins-only stand-alone operation; the C_LIMIT_CC register bit still counts in stand-alone.
// - Without enable or any mode control, stay in sleep or detect unless host activates.
// - Stand-alone: shared data pin picks latched or auto-recovery fault handling.
// - Stand-alone: shared clock pin enables attach and removal detection.
// - Active-low open-drain fault flag signals error events.
// - Active-low open-drain attach flag signals a qualified attach.
// - Attach only after current stays above threshold longer than attach time.
// - Removal only after current stays below threshold longer than removal time.
// - Trip mode opens the power switch when current reaches the limit.
// - Constant-current mode keeps running, opens switch when output voltage too low.
// - Five active modes: pass-through, SDP, CDP, DCP, dedicated charger emulation.
// - CDP keeps the high-speed data switch closed.
// - SDP closes the high-speed data switch.
// - Dedicated charger emulation keeps data path open by default.
// - Near thermal limit, limits and limiting mode adjust to cut dissipation.
// - Attach threshold programmable 200 to 1000 uA, default 800 uA.
// - Removal threshold programmable 100 to 900 uA, default 700 uA.
// - Attach flag asserts nominally 100 ms after qualifying attach begins.
module port_power_ctrl #(
  parameter int unsigned ATTACH_CYCLES = power_ctrl_pkg::ATTACH_CYCLES,
  parameter int unsigned REMOVAL_CYCLES = power_ctrl_pkg::REMOVAL_CYCLES,
  parameter int unsigned RETRY_CYCLES = power_ctrl_pkg::RETRY_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Control pins
  input wire logic mode_select_a_i,
  input wire logic mode_select_b_i,
  input wire logic emulation_select_i,
  input wire logic port_switch_enable_i,
  input wire logic polarity_select_i,
  input wire logic interface_select_i,
  input wire logic latch_select_i,
  input wire logic detect_function_enable_i,
  // Port sensing
  input wire logic [21:0] bus_current_i,
  input wire logic vbus_below_min_i,
  input wire logic thermal_near_i,
  // Switches
  output logic power_switch_on_o,
  output logic high_speed_switch_o,
  output logic cc_mode_o,
  // Open-drain flags
  output logic attach_flag_n_o,
  output logic attach_oe_n_o,
  output logic fault_flag_n_o,
  output logic fault_oe_n_o
);
  import power_ctrl_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [CTRL_W-1:0] ctrl;
  logic [9:0] att_thr;
  logic [9:0] rem_thr;
  logic [21:0] limit;
  logic fault_latched;
  logic attached;
  logic next_attached;
  logic [31:0] qual_cnt;
  logic [31:0] next_qual;
  power_state_t state;
  power_state_t next_state;

  // Merge write data into a register under the byte lanes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Keep a threshold inside its programmable range
  function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo,
                                       input logic [9:0] hi);
    if (v < lo) begin
      return lo;
    end
    return (v > hi) ? hi : v;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two stages before any logic reads a pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= {detect_function_enable_i, latch_select_i, interface_select_i,
                   polarity_select_i, port_switch_enable_i, emulation_select_i,
                   mode_select_b_i, mode_select_a_i};
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // Effective controls
  // ----------------------------------------
  // Register bits only count on the register interface; C_LIMIT_CC counts in both
  wire smbus_sel = pin_sync[P_IFSEL];
  wire [CTRL_W-1:0] set_bits = smbus_sel ? ctrl : '0;
  wire port_pin = pin_sync[P_POL] ? pin_sync[P_PORT_EN] : ~pin_sync[P_PORT_EN];
  wire port_en = port_pin | set_bits[C_PORT_EN];
  wire mode_a = pin_sync[P_MODE_A] | set_bits[C_MODE_A];
  wire mode_b = pin_sync[P_MODE_B] | set_bits[C_MODE_B];
  wire emul = pin_sync[P_EMUL] | set_bits[C_EMUL];
  wire host_act = set_bits[C_HOST_ACT];
  wire detect_en = smbus_sel ? ctrl[C_DETECT_EN] : pin_sync[P_DETECT];
  wire latch_mode = smbus_sel ? ctrl[C_LATCH] : pin_sync[P_LATCH];
  wire run_ok = (port_en && (mode_a | mode_b | emul)) || host_act;

  // Active mode decode; emulation picks the charger modes
  wire active_mode_t mode = emul ? (mode_b ? MODE_DCP : MODE_DCE)
                                 : active_mode_t'({1'b0, mode_b, mode_a});
  // Data modes close the switch; charger modes only when software allows
  wire hs_mode = (mode == MODE_PASS) || (mode == MODE_SDP) || (mode == MODE_CDP)
                 || (((mode == MODE_DCE) || (mode == MODE_DCP)) && set_bits[C_DCE_DATA]);

  // ----------------------------------------
  // Current limiting
  // ----------------------------------------
  // Halved limit and soft limiting near the thermal limit trade power for heat
  wire cc_eff = ctrl[C_LIMIT_CC] | thermal_near_i;
  wire [21:0] eff_limit = thermal_near_i ? {1'b0, limit[21:1]} : limit;
  wire trip_hit = !cc_eff && (bus_current_i >= eff_limit);
  wire cc_hit = cc_eff && vbus_below_min_i;
  wire fault_event = (state == ST_ACTIVE) && (trip_hit || cc_hit);

  // ----------------------------------------
  // Attach and removal qualification
  // ----------------------------------------
  wire attach_cond = (state == ST_DETECT) && (bus_current_i > {12'h000, att_thr});
  wire remove_cond = (state == ST_ACTIVE) && detect_en
                     && (bus_current_i < {12'h000, rem_thr});
  wire attach_hit = attach_cond && (qual_cnt == ATTACH_CYCLES);
  wire remove_hit = remove_cond && (qual_cnt == REMOVAL_CYCLES);
  wire retry_done = (state == ST_ERROR) && (qual_cnt == RETRY_CYCLES);
  wire err_leave = latch_mode ? (!fault_latched || !run_ok) : retry_done;
  wire qual_cond = attach_cond || remove_cond || (state == ST_ERROR);

  // Any lapse of the condition or change of state starts over
  assign next_qual = (qual_cond && (next_state == state)) ? qual_cnt + 32'h1 : 32'h0;
  assign next_attached = (attached || attach_hit) && !remove_hit
                         && (next_state != ST_SLEEP);

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_SLEEP, ST_DETECT: begin
        if (!run_ok) begin
          next_state = detect_en ? ST_DETECT : ST_SLEEP;
        end else if (!detect_en || attach_hit) begin
          next_state = ST_ACTIVE;
        end else begin
          next_state = ST_DETECT;
        end
      end
      ST_ACTIVE: begin
        if (fault_event) begin
          next_state = ST_ERROR;
        end else if (!run_ok) begin
          next_state = detect_en ? ST_DETECT : ST_SLEEP;
        end else if (remove_hit) begin
          next_state = ST_DETECT;
        end
      end
      ST_ERROR: begin
        if (err_leave) begin
          next_state = ST_SLEEP;
        end
      end
      default: next_state = ST_SLEEP;
    endcase
  end

  // State, timer and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_SLEEP;
      qual_cnt <= 32'h0;
      attached <= 1'b0;
    end else begin
      state <= next_state;
      qual_cnt <= next_qual;
      attached <= next_attached;
    end
  end

  // Switch and flag outputs registered from next values so they track the state exactly; cc_mode_o follows cc_eff
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_switch_on_o <= 1'b0;
      high_speed_switch_o <= 1'b0;
      cc_mode_o <= 1'b0;
      attach_flag_n_o <= 1'b0;
      attach_oe_n_o <= 1'b1;
      fault_flag_n_o <= 1'b0;
      fault_oe_n_o <= 1'b1;
    end else begin
      power_switch_on_o <= (next_state == ST_ACTIVE);
      high_speed_switch_o <= (next_state == ST_ACTIVE) && hs_mode;
      cc_mode_o <= cc_eff;
      attach_flag_n_o <= 1'b0;
      attach_oe_n_o <= !next_attached;
      fault_flag_n_o <= 1'b0;
      fault_oe_n_o <= (next_state != ST_ERROR);
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // One wait state; writes land on the ack edge, unmapped reads return zero
  wire wb_req = wb_cyc_i && wb_stb_i;
  wire wr_en = wb_req && wb_we_i && wb_ack_o;
  wire [7:0] word_adr = {wb_adr_i[7:2], 2'b00};
  wire wr_ctrl = wr_en && (word_adr == OFS_CTRL);
  wire wr_att = wr_en && (word_adr == OFS_ATT_THR);
  wire wr_rem = wr_en && (word_adr == OFS_REM_THR);
  wire wr_lim = wr_en && (word_adr == OFS_LIMIT);
  wire fault_clr = wr_en && (word_adr == OFS_STATUS) && wb_sel_i[0] && wb_dat_i[S_FAULT];
  wire [31:0] status = {25'h0, cc_mode_o, power_switch_on_o, high_speed_switch_o,
                        fault_latched, attached, state};
  wire [31:0] m_ctrl = wmerge({23'h0, ctrl}, wb_dat_i, wb_sel_i);
  wire [31:0] m_att = wmerge({22'h0, att_thr}, wb_dat_i, wb_sel_i);
  wire [31:0] m_rem = wmerge({22'h0, rem_thr}, wb_dat_i, wb_sel_i);
  wire [31:0] m_lim = wmerge({10'h0, limit}, wb_dat_i, wb_sel_i);
  wire [31:0] rd_mux = (word_adr == OFS_CTRL) ? {23'h0, ctrl} :
                       (word_adr == OFS_ATT_THR) ? {22'h0, att_thr} :
                       (word_adr == OFS_REM_THR) ? {22'h0, rem_thr} :
                       (word_adr == OFS_LIMIT) ? {10'h0, limit} :
                       (word_adr == OFS_STATUS) ? status : 32'h0;

  // Bus handshake and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      wb_dat_o <= (wb_req && !wb_ack_o) ? rd_mux : 32'h0;
    end
  end

  // Registers; a new fault beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      att_thr <= ATT_THR_DEF;
      rem_thr <= REM_THR_DEF;
      limit <= LIMIT_DEF;
      fault_latched <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= m_ctrl[CTRL_W-1:0];
      if (wr_att) att_thr <= clamp(m_att[9:0], ATT_THR_MIN, ATT_THR_MAX);
      if (wr_rem) rem_thr <= clamp(m_rem[9:0], REM_THR_MIN, REM_THR_MAX);
      if (wr_lim) limit <= m_lim[21:0];
      fault_latched <= fault_event || (fault_latched && !fault_clr);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_trip_opens: assert property (state == ST_ACTIVE && trip_hit |=>
    state == ST_ERROR && !power_switch_on_o && !fault_oe_n_o)
    else $error("trip did not open switch");
  a_cc_vbus_min: assert property (state == ST_ACTIVE && cc_eff && vbus_below_min_i |=>
    !power_switch_on_o) else $error("low vbus did not open switch");
  a_cc_keeps_on: assert property (state == ST_ACTIVE && cc_eff && !vbus_below_min_i
    && run_ok && !remove_hit |=> power_switch_on_o) else $error("cc mode dropped switch");
  a_sleep_hold: assert property (!run_ok |=> state inside {ST_SLEEP, ST_DETECT}
    || $past(state) == ST_ERROR || $past(fault_event)) else $error("left sleep without enable");
  a_attach_qual: assert property ($rose(attached) |->
    $past(qual_cnt) == ATTACH_CYCLES && $past(state) == ST_DETECT)
    else $error("attach without full qualification");
  a_attach_flag: assert property ($rose(attached) |-> !attach_oe_n_o)
    else $error("attach flag not driven");
  a_removal_qual: assert property ($past(state) == ST_ACTIVE && state == ST_DETECT
    && $past(run_ok) && !$past(fault_event) |-> $past(qual_cnt) == REMOVAL_CYCLES)
    else $error("removal without full qualification");
  a_qual_restart: assert property (state == ST_DETECT && !attach_cond |=>
    qual_cnt == 32'h0) else $error("timer kept running");
  a_hs_switch: assert property (next_state == ST_ACTIVE && mode inside {MODE_SDP, MODE_CDP}
    |=> high_speed_switch_o) else $error("data switch not closed");
  a_dce_no_data: assert property (mode == MODE_DCE && !set_bits[C_DCE_DATA] |=>
    !high_speed_switch_o) else $error("data switch closed in emulation");
  a_thermal_cc: assert property (thermal_near_i |=> cc_mode_o)
    else $error("thermal did not force soft limiting");
  a_thr_range: assert property (att_thr >= ATT_THR_MIN && att_thr <= ATT_THR_MAX
    && rem_thr >= REM_THR_MIN && rem_thr <= REM_THR_MAX) else $error("threshold out of range");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");

  c_attach: cover property ($rose(attached));
  c_removal: cover property (state == ST_ACTIVE ##1 state == ST_DETECT);
  c_trip: cover property (state == ST_ACTIVE ##1 state == ST_ERROR ##[1:20] state == ST_SLEEP);
  c_fault_clr: cover property (fault_clr && fault_latched);

endmodule // port_power_ctrl

// [src/power_ctrl_pkg.sv]
// Constants, field layout and state codes of the USB port power control logic.
// Assumes one 125 MHz system clock; times are given in ms and turned into cycles.
package power_ctrl_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_KHZ = 125000;
  localparam int unsigned ATTACH_TIME_MS = 100;
  localparam int unsigned REMOVAL_TIME_MS = 1000;
  localparam int unsigned RETRY_TIME_MS = 10;
  localparam int unsigned ATTACH_CYCLES = ATTACH_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned REMOVAL_CYCLES = REMOVAL_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned RETRY_CYCLES = RETRY_TIME_MS * CLK_FREQ_KHZ;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ATT_THR = 8'h04;
  localparam logic [7:0] OFS_REM_THR = 8'h08;
  localparam logic [7:0] OFS_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ----------------------------------------
  // Control fields and reset values
  // ----------------------------------------
  localparam int CTRL_W = 9;
  localparam int C_MODE_A = 0;
  localparam int C_MODE_B = 1;
  localparam int C_EMUL = 2;
  localparam int C_PORT_EN = 3;
  localparam int C_HOST_ACT = 4;
  localparam int C_DETECT_EN = 5;
  localparam int C_LATCH = 6;
  localparam int C_LIMIT_CC = 7;
  localparam int C_DCE_DATA = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;

  // Thresholds in microamperes
  localparam logic [9:0] ATT_THR_MIN = 10'h0c8;
  localparam logic [9:0] ATT_THR_MAX = 10'h3e8;
  localparam logic [9:0] ATT_THR_DEF = 10'h320;
  localparam logic [9:0] REM_THR_MIN = 10'h064;
  localparam logic [9:0] REM_THR_MAX = 10'h384;
  localparam logic [9:0] REM_THR_DEF = 10'h2bc;
  localparam logic [21:0] LIMIT_DEF = 22'h2dc6c0;

  // Status fields
  localparam int S_ATTACHED = 2;
  localparam int S_FAULT = 3;
  localparam int S_HS_SW = 4;
  localparam int S_POWER = 5;
  localparam int S_CC = 6;

  // Pin vector positions
  localparam int P_MODE_A = 0;
  localparam int P_MODE_B = 1;
  localparam int P_EMUL = 2;
  localparam int P_PORT_EN = 3;
  localparam int P_POL = 4;
  localparam int P_IFSEL = 5;
  localparam int P_LATCH = 6;
  localparam int P_DETECT = 7;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_DETECT = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_ERROR = 2'b11
  } power_state_t;

  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_PASS = 3'b001,
    MODE_SDP = 3'b010,
    MODE_CDP = 3'b011,
    MODE_DCP = 3'b100,
    MODE_DCE = 3'b101
  } active_mode_t;

endpackage

// [tb/port_load_model.sv]
// Portable device and port sense path seen from the power controller.
// Assumes the bench sets the load current and output sag; one clock, sync reset.
`timescale 1ns/1ps

module port_load_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Commands from the bench
  input wire logic [21:0] load_ua_i,
  input wire logic sag_i,
  input wire logic switch_on_i,
  // Sense outputs
  output logic [21:0] bus_current_o,
  output logic vbus_below_min_o
);
  // ----------------------------------------
  // Sense path
  // ----------------------------------------
  // Registered like a real sampler, so a load step lands one cycle late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_current_o <= 22'h000000;
      vbus_below_min_o <= 1'b0;
    end else begin
      bus_current_o <= load_ua_i;
      vbus_below_min_o <= sag_i & switch_on_i; // No sag while the switch is open
    end
  end
endmodule // port_load_model

// [tb/port_power_ctrl_tb.sv]
// Self-checking bench of the port power control logic.
// Assumes shortened qualification counts and a load model on the sense inputs.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module port_power_ctrl_tb;
  import power_ctrl_pkg::*;
  localparam int unsigned AT = 20;
  localparam int unsigned RM = 40;
  localparam int unsigned RT = 10;
  localparam int O_FLT = 4;
  localparam int O_ATT = 3;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] pins;
  logic [21:0] load_ua = 22'h0;
  logic sag = 1'b0;
  logic thermal = 1'b0;
  logic [21:0] cur;
  logic vlow;
  logic pwr, hs, cc, att_v, att_oe_n, flt_v, flt_oe_n;
  logic [4:0] obsv;
  logic [31:0] rd;
  logic [31:0] lfsr = 32'd93254;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  assign obsv = {flt_oe_n, att_oe_n, pwr, hs, cc};

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // Whole run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  port_power_ctrl #(.ATTACH_CYCLES(AT), .REMOVAL_CYCLES(RM), .RETRY_CYCLES(RT)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mode_select_a_i(pins[P_MODE_A]), .mode_select_b_i(pins[P_MODE_B]),
    .emulation_select_i(pins[P_EMUL]), .port_switch_enable_i(pins[P_PORT_EN]),
    .polarity_select_i(pins[P_POL]), .interface_select_i(pins[P_IFSEL]),
    .latch_select_i(pins[P_LATCH]), .detect_function_enable_i(pins[P_DETECT]),
    .bus_current_i(cur), .vbus_below_min_i(vlow), .thermal_near_i(thermal),
    .power_switch_on_o(pwr), .high_speed_switch_o(hs), .cc_mode_o(cc),
    .attach_flag_n_o(att_v), .attach_oe_n_o(att_oe_n),
    .fault_flag_n_o(flt_v), .fault_oe_n_o(flt_oe_n));

  port_load_model load (.clk_i(clk_i), .rst_i(rst_i), .load_ua_i(load_ua), .sag_i(sag),
    .switch_on_i(pwr), .bus_current_o(cur), .vbus_below_min_o(vlow));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] pv(input logic det, input logic lat, input logic ifs,
                                    input logic pol, input logic en, input logic [2:0] m);
    logic [7:0] p;
    p = 8'h00;
    p[P_DETECT] = det;
    p[P_LATCH] = lat;
    p[P_IFSEL] = ifs;
    p[P_POL] = pol;
    p[P_PORT_EN] = en;
    p[P_MODE_A] = m[0];
    p[P_MODE_B] = m[1];
    p[P_EMUL] = m[2];
    return p;
  endfunction

  // Threshold writes saturate rather than wrap
  function automatic logic [31:0] clamp(input logic [9:0] v, input logic [9:0] lo,
                                        input logic [9:0] hi);
    return {22'h0, (v < lo) ? lo : ((v > hi) ? hi : v)};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One step of the bench's feedback shift register
  function automatic void rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
  endfunction

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) failures++;
  endtask

  // Pins pass two sync flops and a state edge before they show
  task automatic pin(input logic [7:0] p);
    pins <= p;
    tick(6);
  endtask

  task automatic wait_obs(input int k, input logic v, input int lim, input string nm);
    int n;
    n = 0;
    while (obsv[k] !== v && n < lim) begin
      tick(1);
      n++;
    end
    `CHK(nm, v, obsv[k])
  endtask

  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    pins = pv(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'b001);
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    `CHK("attach_oe_n", 1'b1, att_oe_n)
    `CHK("attach_val", 1'b0, att_v)
    `CHK("fault_oe_n", 1'b1, flt_oe_n)
    `CHK("fault_val", 1'b0, flt_v)
    wb(1'b0, OFS_ATT_THR, 32'h0);
    `CHK("att_thr", {22'h0, ATT_THR_DEF}, rd)
    wb(1'b0, OFS_REM_THR, 32'h0);
    `CHK("rem_thr", {22'h0, REM_THR_DEF}, rd)
    wb(1'b0, OFS_LIMIT, 32'h0);
    `CHK("limit", {10'h0, LIMIT_DEF}, rd)
    wb(1'b1, 8'h14, 32'hffffffff);
    wb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    // Random threshold values, reaching only the low clamp end of the attach threshold
    for (int i = 0; i < 6; i++) begin
      rnd();
      wb(1'b1, OFS_ATT_THR, {22'h0, lfsr[9:0]});
      wb(1'b0, OFS_ATT_THR, 32'h0);
      `CHK("att_clamp", clamp(lfsr[9:0], ATT_THR_MIN, ATT_THR_MAX), rd)
      wb(1'b1, OFS_REM_THR, {22'h0, lfsr[19:10]});
      wb(1'b0, OFS_REM_THR, 32'h0);
      `CHK("rem_clamp", clamp(lfsr[19:10], REM_THR_MIN, REM_THR_MAX), rd)
    end
    wb(1'b1, OFS_ATT_THR, {22'h0, ATT_THR_DEF});
    wb(1'b1, OFS_REM_THR, {22'h0, REM_THR_DEF});
    $display("test registers done");
    // Every mode code on the pins, detection off
    for (int i = 0; i < 8; i++) begin
      pin(pv(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, i[2:0]));
      `CHK("mode_power", logic'(i != 0), pwr)
      `CHK("mode_hs", logic'(i >= 1 && i <= 3), hs)
    end
    pin(pv(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'b001));
    `CHK("pol_low_off", 1'b0, pwr)
    pin(pv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'b001));
    `CHK("pol_low_on", 1'b1, pwr)
    $display("test modes done");
    // Attach with one dip in mid-qualification, then removal
    // Drop enable first so the port falls back to detect instead of qualifying a removal
    pin(pv(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'b001));
    pin(pv(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'b001));
    `CHK("detect_idle", 1'b0, pwr)
    rnd();
    load_ua <= 22'(ATT_THR_DEF) + 22'd1 + 22'(lfsr[5:0]);
    tick(AT - 4);
    load_ua <= 22'h0;
    tick(1);
    load_ua <= 22'(ATT_THR_DEF) + 22'd1;
    tick(AT - 3);
    `CHK("no_early_attach", 1'b1, att_oe_n)
    wait_obs(O_ATT, 1'b0, 8, "attach");
    `CHK("attach_power", 1'b1, pwr)
    load_ua <= 22'(REM_THR_DEF) - 22'd1;
    tick(RM - 3);
    `CHK("no_early_removal", 1'b0, att_oe_n)
    wait_obs(O_ATT, 1'b1, 8, "removal");
    `CHK("removal_power", 1'b0, pwr)
    $display("test detection done");
    // Trip at exactly the limit, auto-recovery then latched handling
    load_ua <= 22'h0;
    pin(pv(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'b001));
    load_ua <= LIMIT_DEF;
    wait_obs(O_FLT, 1'b0, 4, "trip");
    `CHK("trip_power", 1'b0, pwr)
    load_ua <= 22'h0;
    tick(RT - 4);
    `CHK("retry_hold", 1'b0, flt_oe_n)
    wait_obs(O_FLT, 1'b1, 10, "auto_recover");
    pin(pv(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 3'b001));
    load_ua <= LIMIT_DEF;
    wait_obs(O_FLT, 1'b0, 4, "trip_latched");
    load_ua <= 22'h0;
    tick(3 * RT);
    `CHK("latched", 1'b0, flt_oe_n)
    pin(pv(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 3'b001));
    wait_obs(O_FLT, 1'b1, 6, "latch_clear");
    $display("test faults done");
    // Register control OR'd with pins only in register mode
    pin(pv(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 3'b000));
    `CHK("reg_idle", 1'b0, pwr)
    wb(1'b1, OFS_CTRL, 32'h1 << C_MODE_A | 32'h1 << C_PORT_EN);
    tick(4);
    `CHK("reg_on", 1'b1, pwr)
    wb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status_state", 2'(ST_ACTIVE), rd[1:0])
    `CHK("status_power", 1'b1, rd[S_POWER])
    `CHK("fault_sticky", 1'b1, rd[S_FAULT])
    wb(1'b1, OFS_STATUS, 32'h1 << S_FAULT);
    wb(1'b0, OFS_STATUS, 32'h0);
    `CHK("fault_cleared", 1'b0, rd[S_FAULT])
    pin(pv(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'b000));
    `CHK("standalone_ignores", 1'b0, pwr)
    // Constant-current: survives the limit, opens on low output voltage
    pin(pv(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 3'b000));
    wb(1'b1, OFS_CTRL, 32'h1 << C_MODE_A | 32'h1 << C_LIMIT_CC);
    tick(4);
    load_ua <= LIMIT_DEF + 22'd5;
    tick(10);
    `CHK("cc_power", 1'b1, pwr)
    `CHK("cc_flag", 1'b1, cc)
    sag <= 1'b1;
    wait_obs(O_FLT, 1'b0, 5, "cc_sag");
    sag <= 1'b0;
    load_ua <= 22'h0;
    wait_obs(O_FLT, 1'b1, RT + 10, "cc_recover");
    wb(1'b1, OFS_CTRL, 32'h1 << C_MODE_A);
    tick(4);
    `CHK("trip_mode", 1'b0, cc)
    thermal <= 1'b1;
    tick(3);
    `CHK("thermal_cc", 1'b1, cc)
    thermal <= 1'b0;
    $display("test register mode done");
    end_of_test();
  end
endmodule // port_power_ctrl_tb
